// ===== logic/nvc_pkg.sv
// package of constants and types for the nonvolatile byte store access controller
//**********************************************************************
// Contract
// - nine-bit linear address, high register bit 0
// - software loads address before any access
// - data register holds program byte or read byte
// - mode bits pick atomic, erase, write, reserved
// - mode writes ignored while busy
// - reset clears mode unless still programming; here every reset clears mode and stops the array timer
// - ready interrupt while idle and enabled
// - master enable self-clears after four cycles
// - program starts only within master window
// - busy bit holds until program time ends
// - program launch stalls processor two cycles
// - read strobe fetches byte, stalls four cycles
// - busy blocks reads and address changes
// - software polls busy before read strobe
// - top control bits read zero
// - busy refuses every other array operation
// - write-only onto unerased byte gives undefined data
// - program timing from oscillator timebase
//**********************************************************************
package nvc_pkg;
	localparam int unsigned NVC_ADDR_W = 9;
	localparam logic [8:0] NVC_DEPTH_LAST = 9'h1ff;
	// register offsets in the processor's i/o space
	localparam logic [5:0] NVC_OFS_CTRL = 6'h1c;
	localparam logic [5:0] NVC_OFS_DATA = 6'h1d;
	localparam logic [5:0] NVC_OFS_ADRL = 6'h1e;
	localparam logic [5:0] NVC_OFS_ADRH = 6'h1f;
	// control register field positions
	localparam int unsigned NVC_BIT_READ = 0;
	localparam int unsigned NVC_BIT_PROG = 1;
	localparam int unsigned NVC_BIT_MASTER = 2;
	localparam int unsigned NVC_BIT_RIE = 3;
	localparam int unsigned NVC_BIT_MODE_LO = 4;
	localparam int unsigned NVC_BIT_MODE_HI = 5;
	localparam logic [7:0] NVC_DATA_RESET = 8'h00;
	localparam logic [1:0] NVC_MODE_RESET = 2'h0;
	// cycle figures seen by the processor
	localparam logic [2:0] NVC_MASTER_CYCLES = 3'h4;
	localparam logic [2:0] NVC_PROG_STALL_CYCLES = 3'h2;
	localparam logic [2:0] NVC_READ_STALL_CYCLES = 3'h4;
	// program times in microseconds, counted in oscillator ticks
	localparam int unsigned NVC_T_ATOMIC_US = 3400;
	localparam int unsigned NVC_T_SPLIT_US = 1800;
	localparam int unsigned NVC_TICK_US = 1;
	localparam int unsigned NVC_ATOMIC_TICKS = NVC_T_ATOMIC_US / NVC_TICK_US;
	localparam int unsigned NVC_SPLIT_TICKS = NVC_T_SPLIT_US / NVC_TICK_US;
	localparam int unsigned NVC_CNT_W = 12;
	typedef enum logic [1:0] {
		NVC_MODE_ATOMIC = 2'h0,
		NVC_MODE_ERASE = 2'h1,
		NVC_MODE_WRITE = 2'h2,
		NVC_MODE_RSVD = 2'h3
	} nvc_mode_t;
	typedef enum logic [1:0] {
		NVC_OP_NONE = 2'h0,
		NVC_OP_READ = 2'h1,
		NVC_OP_PROG = 2'h2
	} nvc_op_t;
endpackage

// ===== logic/nvc_if.sv
// interface joining the access controller to the byte array end
`timescale 1ns/1ns
interface nvc_if;
	import nvc_pkg::*;
	logic op_valid;
	nvc_op_t op_kind;
	nvc_mode_t op_mode;
	logic [NVC_ADDR_W-1:0] op_addr;
	logic [7:0] op_wdata;
	logic [7:0] rd_data;
	logic prog_done;
	logic osc_tick;
	modport ctrl (
		output op_valid, op_kind, op_mode, op_addr, op_wdata,
		input rd_data, prog_done, osc_tick
	);
	modport array (
		input op_valid, op_kind, op_mode, op_addr, op_wdata,
		output rd_data, prog_done, osc_tick
	);
endinterface

// ===== logic/nvc_prog_timer.sv
// oscillator-timed down-counter for program durations
`timescale 1ns/1ns
module nvc_prog_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [nvc_pkg::NVC_CNT_W-1:0] count_i,
	output logic busy_o,
	output logic done_o
);
	import nvc_pkg::*;
	logic [NVC_CNT_W-1:0] cnt_reg;
	logic busy_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end else if (load_i && !busy_reg) begin
			cnt_reg <= count_i;
			busy_reg <= 1'b1;
		end else if (busy_reg && tick_i) begin
			// advance only on oscillator ticks, not processor cycles
			if (cnt_reg <= 12'h001) begin
				busy_reg <= 1'b0;
				cnt_reg <= '0;
			end else begin
				cnt_reg <= cnt_reg - 12'h001;
			end
		end
	end
	assign busy_o = busy_reg;
	assign done_o = busy_reg && tick_i && (cnt_reg <= 12'h001);
endmodule

// ===== logic/nvc_array.sv
// byte array end: storage, erase and write actions, oscillator timebase
`timescale 1ns/1ns
module nvc_array (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic osc_tick_i,
	nvc_if.array link
);
	import nvc_pkg::*;
	logic [7:0] mem [0:511];
	logic [7:0] rd_data_reg;
	logic [1:0] pend_mode_reg;
	logic [NVC_ADDR_W-1:0] pend_addr_reg;
	logic [7:0] pend_data_reg;
	logic busy;
	logic done;
	logic load;
	logic [NVC_CNT_W-1:0] count;
	assign load = link.op_valid && link.op_kind == NVC_OP_PROG && !busy;
	always_comb begin
		case (link.op_mode)
			NVC_MODE_ATOMIC: count = NVC_CNT_W'(NVC_ATOMIC_TICKS);
			default: count = NVC_CNT_W'(NVC_SPLIT_TICKS);
		endcase
	end
	nvc_prog_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(osc_tick_i),
		.load_i(load),
		.count_i(count),
		.busy_o(busy),
		.done_o(done)
	);
	always_ff @(posedge clk_i) begin
		if (load) begin
			pend_mode_reg <= link.op_mode;
			pend_addr_reg <= link.op_addr;
			pend_data_reg <= link.op_wdata;
		end
	end
	// contents change only when the program time ends, as the cells would
	always_ff @(posedge clk_i) begin
		if (done) begin
			case (pend_mode_reg)
				NVC_MODE_ATOMIC: mem[pend_addr_reg] <= pend_data_reg;
				NVC_MODE_ERASE: mem[pend_addr_reg] <= 8'hff;
				// unerased target: bitwise and models lost data
				NVC_MODE_WRITE: mem[pend_addr_reg] <= mem[pend_addr_reg] & pend_data_reg;
				default: mem[pend_addr_reg] <= mem[pend_addr_reg];
			endcase
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_reg <= 8'h00;
		end else if (link.op_valid && link.op_kind == NVC_OP_READ && !busy) begin
			rd_data_reg <= mem[link.op_addr];
		end
	end
	assign link.rd_data = rd_data_reg;
	assign link.prog_done = done;
	assign link.osc_tick = osc_tick_i;
endmodule

// ===== logic/nvc_ctrl.sv
// processor-side register block for the nonvolatile byte store
`timescale 1ns/1ns
module nvc_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [5:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	input wire logic global_irq_en_i,
	output logic ready_irq_o,
	output logic cpu_stall_o,
	nvc_if.ctrl link
);
	import nvc_pkg::*;
	//**********************************************************************
	// registers
	//**********************************************************************
	logic [NVC_ADDR_W-1:0] addr_reg;
	logic [7:0] data_reg;
	logic [1:0] mode_reg;
	logic rie_reg;
	logic busy_reg;
	logic [2:0] master_cnt_reg;
	logic [2:0] stall_cnt_reg;
	logic read_pend_reg;
	logic wr_ctrl;
	logic start_prog;
	logic start_read;
	logic master_open;
	assign wr_ctrl = io_wr_i && io_addr_i == NVC_OFS_CTRL;
	assign master_open = master_cnt_reg != 3'h0;
	assign start_prog = wr_ctrl && io_wdata_i[NVC_BIT_PROG] && master_open && !busy_reg
		&& mode_reg != NVC_MODE_RSVD;
	assign start_read = wr_ctrl && io_wdata_i[NVC_BIT_READ] && !busy_reg && !start_prog;
	// address is unknown after reset, so it has no reset term
	always_ff @(posedge clk_i) begin
		if (io_wr_i && !busy_reg) begin
			if (io_addr_i == NVC_OFS_ADRL) begin
				addr_reg[7:0] <= io_wdata_i;
			end
			if (io_addr_i == NVC_OFS_ADRH) begin
				addr_reg[8] <= io_wdata_i[0];
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_reg <= NVC_DATA_RESET;
		end else if (read_pend_reg) begin
			data_reg <= link.rd_data;
		end else if (io_wr_i && io_addr_i == NVC_OFS_DATA) begin
			data_reg <= io_wdata_i;
		end
	end
	// reset also stops the array timer, so no run outlives it and the mode always clears
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= NVC_MODE_RESET;
		end else if (wr_ctrl && !busy_reg) begin
			mode_reg <= io_wdata_i[NVC_BIT_MODE_HI:NVC_BIT_MODE_LO];
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rie_reg <= 1'b0;
		end else if (wr_ctrl) begin
			rie_reg <= io_wdata_i[NVC_BIT_RIE];
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			master_cnt_reg <= 3'h0;
		end else if (wr_ctrl && io_wdata_i[NVC_BIT_MASTER]) begin
			master_cnt_reg <= NVC_MASTER_CYCLES;
		end else if (master_open) begin
			master_cnt_reg <= master_cnt_reg - 3'h1;
		end
	end
	// cleared together with the array timer: a busy flag left standing would lock out every access
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_reg <= 1'b0;
		end else if (start_prog) begin
			busy_reg <= 1'b1;
		end else if (link.prog_done) begin
			busy_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			read_pend_reg <= 1'b0;
		end else begin
			read_pend_reg <= start_read;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stall_cnt_reg <= 3'h0;
		end else if (start_read) begin
			stall_cnt_reg <= NVC_READ_STALL_CYCLES;
		end else if (start_prog) begin
			stall_cnt_reg <= NVC_PROG_STALL_CYCLES;
		end else if (stall_cnt_reg != 3'h0) begin
			stall_cnt_reg <= stall_cnt_reg - 3'h1;
		end
	end
	//**********************************************************************
	// outputs
	//**********************************************************************
	assign cpu_stall_o = stall_cnt_reg != 3'h0;
	assign ready_irq_o = rie_reg && global_irq_en_i && !busy_reg;
	assign link.op_valid = start_prog || start_read;
	assign link.op_kind = start_prog ? NVC_OP_PROG : (start_read ? NVC_OP_READ : NVC_OP_NONE);
	assign link.op_mode = nvc_mode_t'(mode_reg);
	assign link.op_addr = addr_reg;
	assign link.op_wdata = data_reg;
	always_comb begin
		io_rdata_o = 8'h00;
		if (io_rd_i) begin
			case (io_addr_i)
				NVC_OFS_CTRL: io_rdata_o = {2'b00, mode_reg, rie_reg, master_open,
					busy_reg, 1'b0};
				NVC_OFS_DATA: io_rdata_o = data_reg;
				NVC_OFS_ADRL: io_rdata_o = addr_reg[7:0];
				NVC_OFS_ADRH: io_rdata_o = {7'h00, addr_reg[8]};
				default: io_rdata_o = 8'h00;
			endcase
		end
	end
endmodule

// ===== verification/nvc_monitor.sv
// concurrent checks on the controller and its link to the array
`timescale 1ns/1ns
module nvc_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [5:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic global_irq_en_i,
	input wire logic ready_irq_o,
	input wire logic cpu_stall_o,
	input wire logic op_valid,
	input wire nvc_pkg::nvc_op_t op_kind,
	input wire nvc_pkg::nvc_mode_t op_mode,
	input wire logic [nvc_pkg::NVC_ADDR_W-1:0] op_addr,
	input wire logic prog_done
);
	import nvc_pkg::*;
	//********************
	// helper state
	//********************
	logic busy_h;
	logic [2:0] win;
	// cleared by reset: the bench only resets while the array is idle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			busy_h <= 1'b0;
		else if (op_valid && op_kind == NVC_OP_PROG)
			busy_h <= 1'b1;
		else if (prog_done)
			busy_h <= 1'b0;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			win <= 3'h0;
		else if (io_wr_i && io_addr_i == NVC_OFS_CTRL && io_wdata_i[NVC_BIT_MASTER])
			win <= NVC_MASTER_CYCLES;
		else if (win != 3'h0)
			win <= win - 3'h1;
	end
	//********************
	// properties
	//********************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence prog_start; op_valid && op_kind == NVC_OP_PROG; endsequence
	sequence read_start; op_valid && op_kind == NVC_OP_READ; endsequence
	sequence stall_two; cpu_stall_o [*2] ##1 !cpu_stall_o; endsequence
	sequence stall_four; cpu_stall_o [*4] ##1 !cpu_stall_o; endsequence
	prog_stall_a: assert property (prog_start |=> stall_two)
		else $error("stall after program launch");
	read_stall_a: assert property (read_start |=> stall_four)
		else $error("stall after read strobe");
	busy_refuse_a: assert property (op_valid |-> !busy_h)
		else $error("operation while busy");
	open_window_a: assert property (prog_start |-> win != 3'h0)
		else $error("program outside master window");
	no_reserved_a: assert property (prog_start |-> op_mode != NVC_MODE_RSVD)
		else $error("reserved mode launched");
	mode_hold_a: assert property (busy_h && !prog_done |=> $stable(op_mode))
		else $error("mode changed while busy");
	addr_hold_a: assert property (busy_h && !prog_done |=> $stable(op_addr))
		else $error("address changed while busy");
	ready_idle_a: assert property (ready_irq_o |-> !busy_h && global_irq_en_i)
		else $error("ready interrupt while busy");
	done_pulse_a: assert property (prog_done |-> busy_h ##1 !prog_done)
		else $error("stray program done");
endmodule

// ===== verification/nvc_bench.sv
// self-checking bench joining controller and array through the link
`timescale 1ns/1ns
module nvc_bench;
	import nvc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [5:0] io_addr_i = 6'h00;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [7:0] io_wdata_i = 8'h00;
	logic [7:0] io_rdata_o;
	logic ready_irq_o;
	logic cpu_stall_o;
	logic tick = 1'b0;
	logic irq_en = 1'b1;
	logic irq_look = 1'b0;
	logic qi[$];
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] q[$];
	logic [8:0] a;
	logic [7:0] d;
	logic [7:0] d2;
	nvc_if link();
	nvc_ctrl i_nvc_ctrl(.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
		.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
		.io_rdata_o(io_rdata_o), .global_irq_en_i(irq_en), .ready_irq_o(ready_irq_o),
		.cpu_stall_o(cpu_stall_o), .link(link));
	nvc_array i_nvc_array(.clk_i(clk_i), .rst_i(rst_i), .osc_tick_i(tick), .link(link));
	nvc_monitor i_nvc_monitor(.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
		.io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .global_irq_en_i(irq_en),
		.ready_irq_o(ready_irq_o), .cpu_stall_o(cpu_stall_o), .op_valid(link.op_valid),
		.op_kind(link.op_kind), .op_mode(link.op_mode), .op_addr(link.op_addr),
		.prog_done(link.prog_done));
	//********************
	// clock, timebase and result watcher
	//********************
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	// one oscillator tick every two clocks keeps program times short
	always @(posedge clk_i) begin
		tick <= ~tick;
	end
	task automatic print_verdict();
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_irq(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (io_rd_i)
			cmp(io_rdata_o, q.pop_front());
		if (irq_look)
			cmp_irq(ready_irq_o, qi.pop_front());
		if (cyc == 30000) begin
			miscompares++;
			print_verdict();
		end
	end
	//********************
	// bus tasks
	//********************
	task automatic wr(input logic [5:0] ad, input logic [7:0] v);
		@(posedge clk_i);
		io_wr_i <= 1'b1;
		io_addr_i <= ad;
		io_wdata_i <= v;
		@(posedge clk_i);
		io_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] ad, input logic [7:0] e);
		@(posedge clk_i);
		io_rd_i <= 1'b1;
		io_addr_i <= ad;
		q.push_back(e);
		@(posedge clk_i);
		io_rd_i <= 1'b0;
	endtask
	task automatic irq(input logic e);
		@(posedge clk_i);
		irq_look <= 1'b1;
		qi.push_back(e);
		@(posedge clk_i);
		irq_look <= 1'b0;
	endtask
	task automatic go(input nvc_mode_t m, input logic [8:0] ad, input logic [7:0] v);
		wr(NVC_OFS_ADRH, {7'h00, ad[8]});
		wr(NVC_OFS_ADRL, ad[7:0]);
		wr(NVC_OFS_DATA, v);
		wr(NVC_OFS_CTRL, {2'h0, m, 4'hc});
		wr(NVC_OFS_CTRL, {2'h0, m, 4'he});
	endtask
	task automatic strobe();
		wr(NVC_OFS_CTRL, 8'h09);
		repeat (6) @(posedge clk_i);
	endtask
	task automatic idle();
		repeat (4) @(posedge clk_i);
		while (ready_irq_o !== 1'b1)
			@(posedge clk_i);
	endtask
	//********************
	// main sequence
	//********************
	initial begin
		void'($urandom(32'h4eb8e2cd));
		{a, d} = 17'($urandom);
		d2 = 8'($urandom);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		go(NVC_MODE_ATOMIC, a, d);
		irq(1'b0);
		repeat (4) @(posedge clk_i);
		wr(NVC_OFS_CTRL, 8'h28);
		wr(NVC_OFS_ADRL, ~a[7:0]);
		wr(NVC_OFS_CTRL, 8'h09);
		rd(NVC_OFS_CTRL, 8'h0a);
		idle();
		rd(NVC_OFS_ADRL, a[7:0]);
		rd(NVC_OFS_ADRH, {7'h00, a[8]});
		rd(NVC_OFS_DATA, d);
		wr(NVC_OFS_DATA, ~d);
		strobe();
		rd(NVC_OFS_DATA, d);
		go(NVC_MODE_ERASE, a, d);
		idle();
		strobe();
		rd(NVC_OFS_DATA, 8'hff);
		go(NVC_MODE_WRITE, a, d2);
		idle();
		strobe();
		rd(NVC_OFS_DATA, d2);
		go(NVC_MODE_RSVD, a, ~d2);
		repeat (4) @(posedge clk_i);
		rd(NVC_OFS_CTRL, 8'h38);
		irq(1'b1);
		irq_en <= 1'b0;
		irq(1'b0);
		irq_en <= 1'b1;
		strobe();
		rd(NVC_OFS_DATA, d2);
		wr(NVC_OFS_CTRL, 8'h04);
		repeat (6) @(posedge clk_i);
		rd(NVC_OFS_CTRL, 8'h00);
		wr(NVC_OFS_CTRL, 8'h02);
		rd(NVC_OFS_CTRL, 8'h00);
		wr(NVC_OFS_CTRL, 8'h10);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(NVC_OFS_CTRL, 8'h00);
		rd(NVC_OFS_DATA, NVC_DATA_RESET);
		print_verdict();
	end
endmodule
